// file: hdl/izc_defines.vh
// constants for the impedance calibration sequencer
`ifndef IZC_DEFINES_VH
`define IZC_DEFINES_VH

// ============================================================
// calibration periods, counted in memory command clock cycles
`define IZC_INIT_NCK     12'd1024
`define IZC_OPER_NCK     12'd512
`define IZC_SHORT_NCK    12'd64
// most code steps one short calibration may take
`define IZC_SHORT_STEPS  4'd4

// ============================================================
// reset values of the codes in use (mid scale)
`define IZC_DRV_RST      6'h20
`define IZC_TERM_RST     6'h20

// ============================================================
// positions of the pin inputs inside the synchroniser vector
`define IZC_PIN_CK       0
`define IZC_PIN_LONG     1
`define IZC_PIN_SHORT    2
`define IZC_PIN_SREF     3
`define IZC_PIN_TERM     4
`define IZC_PIN_CMPD     5
`define IZC_PIN_CMPT     6
`define IZC_PIN_N        7

// ============================================================
// sequencer state codes
`define IZC_ST_IDLE      2'd0
`define IZC_ST_CAL       2'd1
`define IZC_ST_XFER      2'd2

`endif

// file: hdl/izc_pin_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module izc_pin_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst,
    // raw pins and filtered levels
    input  wire [WIDTH-1:0] pin,
    output reg  [WIDTH-1:0] level
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;

    // ============================================================
    // per-bit chain; stage1 feeds only stage2 to keep metastability contained
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    stage1[i] <= 1'b0;
                    stage2[i] <= 1'b0;
                    stage3[i] <= 1'b0;
                    level[i]  <= 1'b0;
                end else begin
                    stage1[i] <= pin[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                    // a change counts only once stages two and three agree
                    if (stage2[i] == stage3[i]) begin
                        level[i] <= stage3[i];
                    end
                end
            end
        end
    endgenerate

endmodule

// file: hdl/izc_cal_seq.v
// impedance calibration sequencer: long and short calibration of driver and termination
//
// Notes on behaviour
// - long calibration tunes both driver impedance and termination; used first at power-up.
// - long calibration is accepted whenever idle outside self refresh, not only during initialisation.
// - finished calibration codes are copied into the driver and termination in use.
// - first long calibration after reset completes within the initial calibration period.
// - later long calibrations complete within the operational long calibration period.
// - short calibration tracks drift and completes within the short calibration period.
// - one short calibration corrects a small step within 64 command clocks.
// - calibration current path is switched off once calibration is achieved.
// - calibration commands are accepted during lock time after self refresh exit.
// - leaving self refresh never starts a calibration by itself.
// - termination is off during calibration; the device forces it off itself.
`timescale 1ns/1ps
`include "izc_defines.vh"
module izc_cal_seq #(
    parameter CODE_W      = 6,
    parameter CNT_W       = 12,
    parameter INIT_NCK    = `IZC_INIT_NCK,
    parameter OPER_NCK    = `IZC_OPER_NCK,
    parameter SHORT_NCK   = `IZC_SHORT_NCK,
    parameter SHORT_STEPS = `IZC_SHORT_STEPS
) (
    // system clock and reset
    input  wire              SYS_CLK,
    input  wire              RST,
    // memory command clock and decoded calibration commands (pins)
    input  wire              CK,
    input  wire              LONG_CALIBRATION_CMD,
    input  wire              SHORT_CALIBRATION_CMD,
    input  wire              SELF_REFRESH,
    // termination request from the termination_control_pin and mode setting
    input  wire              TERMINATION_CONTROL_PIN,
    input  wire              TERM_MODE_EN,
    // analog comparator results against the reference resistor (pins)
    input  wire              CMP_DRV_HIGH,
    input  wire              CMP_TERM_HIGH,
    // codes in use and status
    output reg  [CODE_W-1:0] DRIVER_IMPEDANCE_CODE,
    output reg  [CODE_W-1:0] TERMINATION_CODE,
    output reg               TERMINATION_ON,
    output reg               CAL_CURRENT_EN,
    output reg               CAL_BUSY,
    output reg               CAL_DONE,
    output reg               LONG_CAL_SEEN
);

    reg  [1:0]        state;
    reg  [CNT_W-1:0]  cnt;
    reg  [3:0]        steps_left;
    reg               short_mode;
    reg  [CODE_W-1:0] drv_work;
    reg  [CODE_W-1:0] term_work;
    reg               ck_prev;
    wire [`IZC_PIN_N-1:0] pins;
    wire [`IZC_PIN_N-1:0] lvl;
    wire              ck_rise;
    wire              may_step;
    wire [CODE_W-1:0] code_max;

    // ============================================================
    // counter and step loads, cut to the register widths on purpose;
    // a period of one command clock still makes one step, the same as a period of two
    localparam [31:0] INIT_LOAD  = INIT_NCK - 1;
    localparam [31:0] OPER_LOAD  = OPER_NCK - 1;
    localparam [31:0] SHORT_LOAD = SHORT_NCK - 1;
    localparam [31:0] STEP_LOAD  = SHORT_STEPS;
    wire [CNT_W-1:0]  init_load;
    wire [CNT_W-1:0]  oper_load;
    wire [CNT_W-1:0]  short_load;
    wire [3:0]        step_load;

    // loads taken once, so every branch below stays at register width
    assign init_load  = INIT_LOAD[CNT_W-1:0];
    assign oper_load  = OPER_LOAD[CNT_W-1:0];
    assign short_load = SHORT_LOAD[CNT_W-1:0];
    assign step_load  = STEP_LOAD[3:0];

    assign pins = {CMP_TERM_HIGH, CMP_DRV_HIGH, TERMINATION_CONTROL_PIN, SELF_REFRESH,
                   SHORT_CALIBRATION_CMD, LONG_CALIBRATION_CMD, CK};
    assign code_max = {CODE_W{1'b1}};

    // ============================================================
    // pin synchronisers; the command clock is sampled like any pin
    // the clock pays about four system cycles of latency here; the
    // commands share the same delay, so they stay aligned to its edges
    izc_pin_sync #(
        .WIDTH (`IZC_PIN_N)
    ) izc_pin_sync_inst (
        .clk   (SYS_CLK),
        .rst   (RST),
        .pin   (pins),
        .level (lvl)
    );

    // ============================================================
    // rising edge of the filtered command clock
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ck_prev <= 1'b0;
        end else begin
            ck_prev <= lvl[`IZC_PIN_CK];
        end
    end
    assign ck_rise = lvl[`IZC_PIN_CK] & ~ck_prev;

    // long runs step every cycle; short runs only within their step budget
    assign may_step = ~short_mode | (steps_left != 4'h0);

    // ============================================================
    // termination forced off while a calibration runs
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            TERMINATION_ON <= 1'b0;
        end else begin
            TERMINATION_ON <= lvl[`IZC_PIN_TERM] & TERM_MODE_EN
                              & (state == `IZC_ST_IDLE);
        end
    end

    // ============================================================
    // calibration sequencer, advanced once per command clock edge
    // limitation: a command seen while busy is dropped, never queued,
    // so the controller must wait out the full period before the next one
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state                 <= `IZC_ST_IDLE;
            cnt                   <= {CNT_W{1'b0}};
            steps_left            <= 4'h0;
            short_mode            <= 1'b0;
            drv_work              <= `IZC_DRV_RST;
            term_work             <= `IZC_TERM_RST;
            DRIVER_IMPEDANCE_CODE <= `IZC_DRV_RST;
            TERMINATION_CODE      <= `IZC_TERM_RST;
            CAL_CURRENT_EN        <= 1'b0;
            CAL_BUSY              <= 1'b0;
            CAL_DONE              <= 1'b0;
            LONG_CAL_SEEN         <= 1'b0;
        end else begin
            CAL_DONE <= 1'b0;
            if (ck_rise) begin
                case (state)
                    `IZC_ST_IDLE: begin
                        // self refresh exit alone starts nothing; only a command does
                        // no lock-time gating, so commands after exit are taken
                        if (!lvl[`IZC_PIN_SREF] && lvl[`IZC_PIN_LONG]) begin
                            // long tunes both codes, at any idle time outside self refresh
                            state          <= `IZC_ST_CAL;
                            short_mode     <= 1'b0;
                            steps_left     <= 4'h0;
                            drv_work       <= DRIVER_IMPEDANCE_CODE;
                            term_work      <= TERMINATION_CODE;
                            CAL_CURRENT_EN <= 1'b1;
                            CAL_BUSY       <= 1'b1;
                            // first long gets the initial period, later ones the shorter
                            if (LONG_CAL_SEEN) begin
                                cnt <= oper_load;
                            end else begin
                                cnt <= init_load;
                            end
                        end else if (!lvl[`IZC_PIN_SREF] && lvl[`IZC_PIN_SHORT]) begin
                            state          <= `IZC_ST_CAL;
                            short_mode     <= 1'b1;
                            steps_left     <= step_load;
                            drv_work       <= DRIVER_IMPEDANCE_CODE;
                            term_work      <= TERMINATION_CODE;
                            cnt            <= short_load;
                            CAL_CURRENT_EN <= 1'b1;
                            CAL_BUSY       <= 1'b1;
                        end
                    end
                    `IZC_ST_CAL: begin
                        // commands are ignored here; the channel is meant to be quiet
                        if (may_step) begin
                            // step each code one LSB toward its comparator
                            if (lvl[`IZC_PIN_CMPD] && drv_work != code_max) begin
                                drv_work <= drv_work + 1'b1;
                            end else if (!lvl[`IZC_PIN_CMPD] && drv_work != 0) begin
                                drv_work <= drv_work - 1'b1;
                            end
                            if (lvl[`IZC_PIN_CMPT] && term_work != code_max) begin
                                term_work <= term_work + 1'b1;
                            end else if (!lvl[`IZC_PIN_CMPT] && term_work != 0) begin
                                term_work <= term_work - 1'b1;
                            end
                            if (steps_left != 4'h0) begin
                                steps_left <= steps_left - 4'h1;
                            end
                        end
                        cnt <= cnt - 12'd1;
                        if (cnt <= 12'd1) begin
                            // calibration achieved: cut the current path
                            state          <= `IZC_ST_XFER;
                            CAL_CURRENT_EN <= 1'b0;
                        end
                    end
                    `IZC_ST_XFER: begin
                        // hand the result to the I/O in the last cycle of the period
                        DRIVER_IMPEDANCE_CODE <= drv_work;
                        TERMINATION_CODE      <= term_work;
                        if (!short_mode) begin
                            LONG_CAL_SEEN <= 1'b1;
                        end
                        CAL_BUSY <= 1'b0;
                        CAL_DONE <= 1'b1;
                        state    <= `IZC_ST_IDLE;
                    end
                    default: begin
                        state          <= `IZC_ST_IDLE;
                        CAL_CURRENT_EN <= 1'b0;
                        CAL_BUSY       <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule

// file: test/izc_cal_props.sv
// assertion checker on the calibration sequencer ports
`timescale 1ns/1ps
module izc_cal_props (
    // clock and reset
    input wire       SYS_CLK,
    input wire       RST,
    // status and codes
    input wire [5:0] DRIVER_IMPEDANCE_CODE,
    input wire [5:0] TERMINATION_CODE,
    input wire       TERMINATION_ON,
    input wire       CAL_CURRENT_EN,
    input wire       CAL_BUSY,
    input wire       CAL_DONE,
    input wire       LONG_CAL_SEEN
);
    // ============================================================
    // properties, one clock domain
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    a_done_ends_busy: assert property (CAL_DONE |-> !CAL_BUSY && $past(CAL_BUSY))
        else $error("done without busy ending");
    a_done_one_pulse: assert property (CAL_DONE |=> !CAL_DONE)
        else $error("done longer than one cycle");
    a_codes_hold: assert property (!CAL_DONE |->
        $stable(DRIVER_IMPEDANCE_CODE) && $stable(TERMINATION_CODE))
        else $error("codes moved outside a transfer");
    a_term_off_busy: assert property (CAL_BUSY && $past(CAL_BUSY) |-> !TERMINATION_ON)
        else $error("termination on while calibrating");
    a_current_in_cal: assert property (CAL_CURRENT_EN |-> CAL_BUSY && !CAL_DONE)
        else $error("current path on while idle");
    a_current_off_done: assert property ($fell(CAL_CURRENT_EN) |-> ##[6:10] CAL_DONE)
        else $error("current path off too far from transfer");
    a_busy_min_len: assert property ($rose(CAL_BUSY) |-> CAL_BUSY [*8])
        else $error("calibration ended too soon");
    a_busy_bounded: assert property ($rose(CAL_BUSY) |-> ##[1:600] CAL_DONE)
        else $error("calibration never finished");
    a_seen_on_done: assert property ($rose(LONG_CAL_SEEN) |-> CAL_DONE)
        else $error("long flag set without transfer");
    a_seen_sticks: assert property (LONG_CAL_SEEN |=> LONG_CAL_SEEN)
        else $error("long flag dropped");
endmodule

bind izc_cal_seq izc_cal_props izc_cal_props_inst (
    .SYS_CLK(SYS_CLK), .RST(RST), .DRIVER_IMPEDANCE_CODE(DRIVER_IMPEDANCE_CODE),
    .TERMINATION_CODE(TERMINATION_CODE), .TERMINATION_ON(TERMINATION_ON),
    .CAL_CURRENT_EN(CAL_CURRENT_EN), .CAL_BUSY(CAL_BUSY), .CAL_DONE(CAL_DONE),
    .LONG_CAL_SEEN(LONG_CAL_SEEN));

// file: test/izc_ctrl_model.sv
// memory controller model: command clock, calibration commands, self refresh
`timescale 1ns/1ps
module izc_ctrl_model #(
    parameter XSF_NCK = 2
) (
    // command clock and pins
    output reg CK,
    output reg LONG_CALIBRATION_CMD,
    output reg SHORT_CALIBRATION_CMD,
    output reg SELF_REFRESH
);
    // ============================================================
    // free running clock, phase offset keeps it unrelated to SYS_CLK
    initial begin
        CK = 1'b0;
        LONG_CALIBRATION_CMD = 1'b0;
        SHORT_CALIBRATION_CMD = 1'b0;
        SELF_REFRESH = 1'b0;
        #37;
        forever #100 CK = ~CK;
    end
    // one command held a full period around its edge, nothing else sent
    task issue(input reg lng);
        begin
            @(negedge CK);
            LONG_CALIBRATION_CMD <= lng;
            SHORT_CALIBRATION_CMD <= ~lng;
            @(negedge CK);
            LONG_CALIBRATION_CMD <= 1'b0;
            SHORT_CALIBRATION_CMD <= 1'b0;
        end
    endtask
    // self refresh entry or exit; exit waits before any command
    task sref(input reg on);
        begin
            @(negedge CK);
            SELF_REFRESH <= on;
            if (!on) begin
                repeat (XSF_NCK) @(negedge CK);
            end
        end
    endtask
endmodule

// file: test/tb_impedance_calibration_sequencer.sv
// self-checking bench for the impedance calibration sequencer
`timescale 1ns/1ps
module tb_impedance_calibration_sequencer;
    reg        sys_clk, rst, tpin, tmode, cdrv, cterm;
    wire       ck, lng, sht, sref, ton, cur, busy, done, seen;
    wire [5:0] drv, term;
    reg  [5:0] drv0, term0;
    integer    bad_count, checked, ck_n;
    izc_ctrl_model izc_ctrl_model_inst (.CK(ck), .LONG_CALIBRATION_CMD(lng),
        .SHORT_CALIBRATION_CMD(sht), .SELF_REFRESH(sref));
    izc_cal_seq #(.INIT_NCK(8), .OPER_NCK(6), .SHORT_NCK(4)) izc_cal_seq_inst (
        .SYS_CLK(sys_clk), .RST(rst), .CK(ck), .LONG_CALIBRATION_CMD(lng),
        .SHORT_CALIBRATION_CMD(sht), .SELF_REFRESH(sref), .TERMINATION_CONTROL_PIN(tpin),
        .TERM_MODE_EN(tmode), .CMP_DRV_HIGH(cdrv), .CMP_TERM_HIGH(cterm),
        .DRIVER_IMPEDANCE_CODE(drv), .TERMINATION_CODE(term), .TERMINATION_ON(ton),
        .CAL_CURRENT_EN(cur), .CAL_BUSY(busy), .CAL_DONE(done), .LONG_CAL_SEEN(seen));
    // ============================================================
    // clock, edge counter of the command clock while busy
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge ck) if (busy === 1'b1) ck_n = ck_n + 1;
    task check(input [11:0] seen_v, input [11:0] exp_v);
        begin
            checked = checked + 1;
            if (seen_v !== exp_v) begin
                bad_count = bad_count + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
            end
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", checked, bad_count);
            if (bad_count == 0 && checked > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask
    task do_reset;
        begin
            rst <= 1'b1;
            repeat (4) @(posedge sys_clk);
            rst <= 1'b0;
            repeat (6) @(posedge sys_clk);
        end
    endtask
    // one command, then wait for the transfer under a bound
    task run(input reg l);
        integer i;
        begin
            ck_n = 0;
            drv0 = drv;
            term0 = term;
            izc_ctrl_model_inst.issue(l);
            // termination drops one system cycle after busy rises
            wait (busy === 1'b1);
            @(posedge sys_clk);
            #1;
            check(ton, 0);
            i = 0;
            while (i < 2000 && done !== 1'b1) begin
                @(posedge sys_clk);
                #1;
                i = i + 1;
            end
            check(done, 1);
            repeat (2) @(posedge sys_clk);
        end
    endtask
    task t_long;
        begin
            cdrv <= 1'b1;
            cterm <= 1'b0;
            repeat (8) @(posedge sys_clk);
            check(ton, 1);
            run(1);
            check(ck_n, 8);
            check(drv > drv0 && term < term0, 1);
            check(cur, 0);
            check(seen, 1);
            run(1);
            check(ck_n, 6);
            check(drv > drv0, 1);
        end
    endtask
    task t_short;
        begin
            cdrv <= 1'b0;
            cterm <= 1'b1;
            run(0);
            check(ck_n, 4);
            check(drv < drv0 && drv0 - drv <= 4 && term > term0, 1);
        end
    endtask
    // termination follows the pin and the mode enable while idle
    task t_term;
        begin
            tpin <= 1'b0;
            repeat (8) @(posedge sys_clk);
            check(ton, 0);
            tpin <= 1'b1;
            tmode <= 1'b0;
            repeat (8) @(posedge sys_clk);
            check(ton, 0);
            tmode <= 1'b1;
            repeat (8) @(posedge sys_clk);
            check(ton, 1);
        end
    endtask
    // commands in self refresh ignored, exit starts nothing
    task t_sref;
        begin
            izc_ctrl_model_inst.sref(1);
            izc_ctrl_model_inst.issue(0);
            izc_ctrl_model_inst.sref(0);
            repeat (24) @(posedge sys_clk);
            check(busy, 0);
            run(0);
            check(ck_n, 4);
        end
    endtask
    // second reset brings back the initial long period
    task t_rereset;
        begin
            do_reset;
            check(seen, 0);
            check(drv, 6'h20);
            run(1);
            check(ck_n, 8);
        end
    endtask
    // watchdog against a hung handshake
    initial begin
        #100000;
        bad_count = bad_count + 1;
        close_out;
    end
    initial begin
        rst = 1'b1;
        tpin = 1'b1;
        tmode = 1'b1;
        cdrv = 1'b0;
        cterm = 1'b0;
        bad_count = 0;
        checked = 0;
        ck_n = 0;
        do_reset;
        t_long;
        t_short;
        t_term;
        t_sref;
        t_rereset;
        close_out;
    end
endmodule
